// ==== bench/lohc_host.sv ====
module lohc_host
  import lohc_pkg::*;
(
  input wire logic clk, // System clock
  output logic cmd_valid, // Command strobe
  output lohc_cmd_t cmd_code, // Command code
  output logic cmd_has_arg, // Argument present
  output logic [ARG_W-1:0] cmd_arg, // Argument
  input wire logic rsp_valid, // Reply strobe
  input wire lohc_rsp_t rsp_code, // Reply kind
  input wire logic [ARG_W-1:0] rsp_value // Reply value
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cmd_valid = 1'b0;
    cmd_code = CMD_DELAY_QRY;
    cmd_has_arg = 1'b0;
    cmd_arg = '0;
  end

  task automatic send(input lohc_cmd_t c, input logic h, input logic [ARG_W-1:0] a,
                      output logic v, output lohc_rsp_t rc, output logic [ARG_W-1:0] rv);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_has_arg = h;
    cmd_arg = a;
    @(posedge clk);
    #1;
    v = rsp_valid;
    rc = rsp_code;
    rv = rsp_value;
    cmd_valid = 1'b0;
    // Released lines change, so a stale argument cannot pass unnoticed
    cmd_has_arg = ~h;
    cmd_arg = ~a;
  endtask
endmodule

// ==== bench/tb.sv ====
module tb;
  import lohc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC = 4;
  logic clk, arst_n, cmd_valid, cmd_has_arg, rsp_valid, panel_button, local_mode;
  lohc_cmd_t cmd_code;
  lohc_rsp_t rsp_code;
  logic [ARG_W-1:0] cmd_arg, rsp_value;
  logic signed [VAL_W-1:0] cur, temp, pz_act, pz_set, coeff, t_lo, t_hi;
  logic laser_on, power_led, ffwd_en, mod_en, sweep_en;
  logic signed [FF_W-1:0] ffwd_current;
  int n_fail, n_compared, cyc, m_delay, m_ref;
  int m_en[5];
  int unsigned dv[7];

  lohc_top #(.MS_CYC(MSC)) i_lohc_top (.clk(clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_has_arg(cmd_has_arg), .cmd_arg(cmd_arg), .rsp_valid(rsp_valid),
    .rsp_code(rsp_code), .rsp_value(rsp_value), .panel_button(panel_button),
    .local_mode(local_mode), .diode_current(cur), .diode_temp(temp), .piezo_actual(pz_act),
    .piezo_setpoint(pz_set), .ffwd_coeff(coeff), .temp_limit_lo(t_lo), .temp_limit_hi(t_hi),
    .laser_on(laser_on), .power_led(power_led), .ffwd_en(ffwd_en), .mod_en(mod_en),
    .sweep_en(sweep_en), .ffwd_current(ffwd_current));

  lohc_host host (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_has_arg(cmd_has_arg), .cmd_arg(cmd_arg), .rsp_valid(rsp_valid),
    .rsp_code(rsp_code), .rsp_value(rsp_value));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Ceiling well above the two full turn-on waits
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 70000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic check(input string what, input logic [FF_W-1:0] seen,
                       input logic [FF_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  function automatic int mag(input logic signed [VAL_W-1:0] x);
    return (x < 0) ? -int'(x) : int'(x);
  endfunction

  function automatic logic signed [VAL_W-1:0] rnd(input int span);
    return VAL_W'(int'($urandom_range(0, 2 * span)) - span);
  endfunction

  // Model predicts the reply and the enable levels for every command
  task automatic cmd(input lohc_cmd_t c, input logic h, input int unsigned a);
    logic v;
    lohc_rsp_t rc, er;
    logic [ARG_W-1:0] rv;
    int ev, k;
    k = int'(c) / 2;
    ev = 0;
    er = RSP_OK;
    if (c > CMD_PIEZO_QRY) er = RSP_UNKNOWN;
    else if (c >= CMD_CUR_QRY) begin
      er = RSP_VALUE;
      ev = mag(c == CMD_CUR_QRY ? cur : (c == CMD_TEMP_QRY ? temp : pz_act));
    end else if (c[0]) begin
      er = RSP_VALUE;
      ev = k ? m_en[k] : m_delay;
    end else if (!h) er = RSP_NO_PARAM;
    else if (k == 0 ? (a < 6000 || a > 60000) : a > 1) er = RSP_RANGE;
    else if (k == 0) m_delay = a;
    else begin
      if (k == 1 && a == 1) m_ref = pz_set;
      m_en[k] = a;
    end
    host.send(c, h, a, v, rc, rv);
    check("rsp_valid", v, 1);
    check("rsp_code", rc, er);
    check("rsp_value", rv, ev);
    check("ffwd_en", ffwd_en, m_en[1]);
    check("mod_en", mod_en, m_en[2]);
    check("sweep_en", sweep_en, m_en[4]);
  endtask

  // Waits for the output to energize, counting cycles and indicator toggles
  task automatic wait_on(input int d, input int slack);
    int n, tog;
    logic prev;
    n = 0;
    tog = 0;
    prev = power_led;
    while (laser_on !== 1'b1 && n < d * MSC + 50) begin
      @(posedge clk);
      #1;
      n++;
      // Skip the first cycles so a button start's initial rise is not a flash
      if (power_led !== prev && n > 8) tog++;
      prev = power_led;
    end
    check("on_cycles", n >= d * MSC - 2 && n <= d * MSC + slack, 1);
    check("flash_toggles", tog >= d / 250 - 1 && tog <= d / 250 + 1, 1);
    check("led_on", power_led, 1);
  endtask

  initial begin
    cyc = 0;
    n_fail = 0;
    n_compared = 0;
    m_delay = 6000;
    m_ref = 0;
    m_en = '{default: 0};
    void'($urandom(52906));
    arst_n = 1'b0;
    panel_button = 1'b0;
    local_mode = 1'b0;
    {cur, pz_act, pz_set, coeff} = '0;
    temp = 16'sh0019;
    t_lo = -16'sh0014;
    t_hi = 16'sh0050;
    repeat (8) @(posedge clk);
    #1;
    arst_n = 1'b1;
    check("laser_on", laser_on, 0);
    check("power_led", power_led, 0);
    check("ffwd_current", ffwd_current, 0);
    cmd(CMD_DELAY_QRY, 0, 0);
    $display("Test reset done");
    for (int k = 0; k < 5; k++) begin
      cmd(lohc_cmd_t'(2 * k), 1'b0, 1);
      cmd(lohc_cmd_t'(2 * k + 1), 1'b0, 0);
    end
    check("laser_on", laser_on, 0);
    $display("Test missing argument done");
    dv = '{5999, 60001, 6000, 60000, 0, 32'h0001_1b58, $urandom_range(6000, 60000)};
    foreach (dv[i]) begin
      cmd(CMD_DELAY_SET, 1'b1, dv[i]);
      cmd(CMD_DELAY_QRY, 1'b0, 0);
    end
    $display("Test delay range done");
    foreach (dv[i]) begin
      if (i < 3) begin
        for (int j = 0; j < 3; j++) begin
          cmd(lohc_cmd_t'(4 * i / 2 + 2 * (i == 2) + 2), 1'b1, j == 0 ? 2 : ($urandom | 2));
          cmd(lohc_cmd_t'(4 * i / 2 + 2 * (i == 2) + 2), 1'b1, j % 2);
          cmd(lohc_cmd_t'(4 * i / 2 + 2 * (i == 2) + 3), 1'b0, 0);
        end
      end
    end
    cmd(lohc_cmd_t'(4'hd), 1'b1, 0);
    cmd(lohc_cmd_t'(4'hf), 1'b0, 0);
    $display("Test enables done");
    pz_set = rnd(1000);
    pz_act = rnd(1000);
    coeff = rnd(100);
    cmd(CMD_FFWD_SET, 1'b1, 1);
    for (int i = 0; i < 4; i++) begin
      pz_set = rnd(1000);
      pz_act = rnd(1000);
      coeff = rnd(100);
      if (i == 3) cmd(CMD_FFWD_SET, 1'b1, 0);
      @(posedge clk);
      #1;
      check("ffwd_current", ffwd_current, m_en[1] ? coeff * (pz_act - m_ref) : 0);
    end
    for (int i = 0; i < 4; i++) begin
      cur = rnd(32767);
      temp = rnd(32767);
      pz_act = i ? rnd(32767) : -16'sh7fff;
      for (int k = 10; k < 13; k++) cmd(lohc_cmd_t'(k), 1'b0, 0);
    end
    temp = 16'sh0019;
    $display("Test feedforward and measurements done");
    cmd(CMD_DELAY_SET, 1'b1, 6000 + $urandom_range(0, 500));
    cmd(CMD_OUT_SET, 1'b1, 1);
    check("led_pending", power_led, 1);
    wait_on(m_delay, 3);
    cmd(CMD_OUT_QRY, 1'b0, 0);
    cmd(CMD_OUT_SET, 1'b1, 0);
    check("laser_off", laser_on, 0);
    cmd(CMD_OUT_SET, 1'b1, 1);
    repeat (1200) @(posedge clk);
    cmd(CMD_OUT_SET, 1'b1, 0);
    check("cancel_laser", laser_on, 0);
    check("cancel_led", power_led, 0);
    $display("Test command turn-on done");
    local_mode = 1'b1;
    panel_button = 1'b1;
    // Sync stages and edge detect add a few cycles at the front
    wait_on(m_delay, 6);
    m_en[3] = 1;
    panel_button = 1'b0;
    cmd(CMD_OUT_QRY, 1'b0, 0);
    temp = t_hi + 16'sh0001;
    m_en[3] = 0;
    repeat (3) @(posedge clk);
    #1;
    check("overtemp_off", laser_on, 0);
    temp = 16'sh0019;
    cmd(CMD_OUT_QRY, 1'b0, 0);
    $display("Test button and over-temperature done");
    finish_test();
  end
endmodule

// ==== common/lohc_pkg.sv ====
package lohc_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLES = (MS_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ARG_W = 32;
  localparam int VAL_W = 16;
  localparam int FF_W = 33;
  localparam logic [15:0] DELAY_MIN_MS = 16'h1770;
  localparam logic [15:0] DELAY_MAX_MS = 16'hea60;
  localparam logic [15:0] DELAY_RST_MS = 16'h1770;
  localparam logic [15:0] FLASH_HALF_MS = 16'h00fa;

  typedef enum logic [3:0] {
    CMD_DELAY_SET = 4'h0,
    CMD_DELAY_QRY = 4'h1,
    CMD_FFWD_SET = 4'h2,
    CMD_FFWD_QRY = 4'h3,
    CMD_MOD_SET = 4'h4,
    CMD_MOD_QRY = 4'h5,
    CMD_OUT_SET = 4'h6,
    CMD_OUT_QRY = 4'h7,
    CMD_SWEEP_SET = 4'h8,
    CMD_SWEEP_QRY = 4'h9,
    CMD_CUR_QRY = 4'ha,
    CMD_TEMP_QRY = 4'hb,
    CMD_PIEZO_QRY = 4'hc
  } lohc_cmd_t;

  typedef enum logic [2:0] {
    RSP_OK = 3'h0,
    RSP_NO_PARAM = 3'h1,
    RSP_RANGE = 3'h2,
    RSP_VALUE = 3'h3,
    RSP_UNKNOWN = 3'h4
  } lohc_rsp_t;

  typedef enum logic [2:0] {
    LS_OFF = 3'b001,
    LS_PEND = 3'b010,
    LS_ON = 3'b100
  } lohc_state_t;
endpackage

// ==== common/lohc_tick_if.sv ====
interface lohc_tick_if;
  logic run;
  logic tick;
  modport gen (input run, output tick);
  modport user (output run, input tick);
endinterface

// ==== logic/lohc_ms_tick.sv ====
module lohc_ms_tick
  import lohc_pkg::*;
#(
  parameter int CYCLES = MS_CYCLES
) (
  input wire logic clk, // System clock
  input wire logic arst_n, // Async reset
  lohc_tick_if.gen t // Run request in, tick out
);
  logic [31:0] cnt;
  wire logic wrap = (cnt == 32'(CYCLES - 1));

  // Restarts on each run so the first tick is a full period away
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= '0;
      t.tick <= 1'b0;
    end else if (!t.run) begin
      cnt <= '0;
      t.tick <= 1'b0;
    end else begin
      cnt <= wrap ? 32'h0 : cnt + 32'h1;
      t.tick <= wrap;
    end
  end
endmodule

// ==== logic/lohc_sync.sv ====
module lohc_sync #(
  parameter int W = 1
) (
  input wire logic clk, // System clock
  input wire logic arst_n, // Async reset
  input wire logic [W-1:0] d, // Asynchronous inputs
  output logic [W-1:0] q // Synchronised outputs
);
  logic [W-1:0] stage1;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      q <= '0;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule

// ==== logic/lohc_top.sv ====
// Overview of operation
// [RL1] Set command without argument answers missing-parameter and changes nothing.
// [RL2] Delay argument below 6000 or above 60000 answers out-of-range, delay kept.
// [RL3] Valid delay argument in milliseconds replaces stored delay, answer OK.
// [RL4] Laser-on command waits the stored delay before energizing the output.
// [RL5] Front-panel button in local mode uses the same stored delay.
// [RL6] Delay query returns stored delay in milliseconds.
// [RL7] Enable commands with argument other than 0 or 1 answer out-of-range.
// [RL8] Enable commands: 0 switches feature off, 1 on, then answer OK.
// [RL9] Enabling feedforward latches the present piezo voltage setpoint.
// [RL10] Feedforward current equals coefficient times actual minus latched piezo voltage.
// [RL11] Enable queries return 0 when off and 1 when on.
// [RL12] Power indicator flashes during the whole pending turn-on delay.
// [RL13] Sweep enable starts frequency modulation; disable stops it.
// [RL14] Current query returns measured diode current magnitude in milliamperes.
// [RL15] Temperature query returns measured diode temperature magnitude in Celsius.
// [RL16] Laser output switches off when diode temperature leaves safe limits.
// [RL17] Piezo query returns measured piezo voltage magnitude in volts.
// [RL18] Off during pending turn-on cancels it and stops flashing at once.
// [RL19] Turn-on delay counts one-millisecond ticks derived from the clock.
module lohc_top
  import lohc_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input wire logic clk, // 100 MHz clock
  input wire logic arst_n, // Async reset, active low
  input wire logic cmd_valid, // Command strobe
  input wire lohc_cmd_t cmd_code, // Command code
  input wire logic cmd_has_arg, // Argument present
  input wire logic [ARG_W-1:0] cmd_arg, // Integer argument
  output logic rsp_valid, // Reply strobe
  output lohc_rsp_t rsp_code, // Reply kind
  output logic [ARG_W-1:0] rsp_value, // Query value
  input wire logic panel_button, // Power button pin
  input wire logic local_mode, // Local control mode pin
  input wire logic signed [VAL_W-1:0] diode_current, // Measured current, mA
  input wire logic signed [VAL_W-1:0] diode_temp, // Measured temperature, degC
  input wire logic signed [VAL_W-1:0] piezo_actual, // Measured piezo, V
  input wire logic signed [VAL_W-1:0] piezo_setpoint, // Piezo setpoint
  input wire logic signed [VAL_W-1:0] ffwd_coeff, // Feedforward coefficient
  input wire logic signed [VAL_W-1:0] temp_limit_lo, // Lowest safe temperature
  input wire logic signed [VAL_W-1:0] temp_limit_hi, // Highest safe temperature
  output logic laser_on, // Output energized
  output logic power_led, // Indicator above button
  output logic ffwd_en, // Feedforward enabled
  output logic mod_en, // Current modulation enabled
  output logic sweep_en, // Sweep generator, drives FM
  output logic signed [FF_W-1:0] ffwd_current // Feedforward current
);
  lohc_state_t state, next_state;
  logic [15:0] delay_ms;
  logic [15:0] remain;
  logic [15:0] flash_cnt;
  logic flash_phase;
  logic signed [VAL_W-1:0] piezo_ref;
  logic [1:0] pins_s;
  logic btn_d;
  logic [ARG_W-1:0] qry_val;

  lohc_tick_if tk ();

  lohc_sync #(.W(2)) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .d({local_mode, panel_button}),
    .q(pins_s)
  );

  lohc_ms_tick #(.CYCLES(MS_CYC)) u_tick (
    .clk(clk),
    .arst_n(arst_n),
    .t(tk.gen)
  );

  function automatic logic [VAL_W-1:0] mag(input logic signed [VAL_W-1:0] v);
    mag = v[VAL_W-1] ? VAL_W'(-v) : VAL_W'(v);
  endfunction

  // Command decode
  wire logic is_en_cmd = (cmd_code == CMD_FFWD_SET) || (cmd_code == CMD_MOD_SET) ||
                         (cmd_code == CMD_OUT_SET) || (cmd_code == CMD_SWEEP_SET);
  wire logic is_set_cmd = is_en_cmd || (cmd_code == CMD_DELAY_SET);
  wire logic is_qry_cmd = (cmd_code == CMD_DELAY_QRY) || (cmd_code == CMD_FFWD_QRY) ||
                          (cmd_code == CMD_MOD_QRY) || (cmd_code == CMD_OUT_QRY) ||
                          (cmd_code == CMD_SWEEP_QRY) || (cmd_code == CMD_CUR_QRY) ||
                          (cmd_code == CMD_TEMP_QRY) || (cmd_code == CMD_PIEZO_QRY);
  wire logic no_arg = cmd_valid && is_set_cmd && !cmd_has_arg; // see [RL1]
  wire logic en_arg_ok = (cmd_arg <= 32'h1); // see [RL7]
  wire logic delay_arg_ok = (cmd_arg >= 32'(DELAY_MIN_MS)) &&
                            (cmd_arg <= 32'(DELAY_MAX_MS)); // see [RL2]
  wire logic arg_ok = is_en_cmd ? en_arg_ok : delay_arg_ok;
  wire logic accept = cmd_valid && is_set_cmd && cmd_has_arg && arg_ok;
  wire logic arg_bit = cmd_arg[0];
  wire logic wr_delay = accept && (cmd_code == CMD_DELAY_SET);
  wire logic wr_ffwd = accept && (cmd_code == CMD_FFWD_SET);
  wire logic wr_mod = accept && (cmd_code == CMD_MOD_SET);
  wire logic wr_out = accept && (cmd_code == CMD_OUT_SET);
  wire logic wr_sweep = accept && (cmd_code == CMD_SWEEP_SET);

  // Turn-on sequencing
  wire logic btn_rise = pins_s[1] && pins_s[0] && !btn_d; // see [RL5]
  wire logic over_temp = (diode_temp > temp_limit_hi) || (diode_temp < temp_limit_lo);
  wire logic st_off = (state == LS_OFF);
  wire logic start_req = (wr_out && arg_bit) || btn_rise;
  // Button toggles: a press while on or pending switches off
  wire logic go_off = over_temp || (wr_out && !arg_bit) ||
                      (btn_rise && !st_off); // see [RL16] [RL18]
  wire logic start_pend = st_off && (next_state == LS_PEND);
  wire logic tick = tk.tick;
  wire logic flash_wrap = tick && (flash_cnt == FLASH_HALF_MS - 16'h1);
  assign tk.run = (state == LS_PEND); // see [RL19]

  always_comb begin
    next_state = state;
    unique case (state)
      LS_OFF: begin
        if (!go_off && start_req) begin
          next_state = LS_PEND;
        end
      end
      LS_PEND: begin
        if (go_off) begin
          next_state = LS_OFF;
        end else if (tick && remain == 16'h1) begin
          next_state = LS_ON; // see [RL4]
        end
      end
      LS_ON: begin
        if (go_off) begin
          next_state = LS_OFF;
        end
      end
      default: next_state = LS_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= LS_OFF;
      laser_on <= 1'b0;
      btn_d <= 1'b0;
    end else begin
      state <= next_state;
      laser_on <= (next_state == LS_ON); // see [RL4] [RL16]
      btn_d <= pins_s[0];
    end
  end

  // Stored delay in ms, counted down by ticks during pending
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      remain <= '0;
    end else if (start_pend) begin
      remain <= delay_ms; // see [RL4] [RL5]
    end else if (state == LS_PEND && tick) begin
      remain <= remain - 16'h1; // see [RL19]
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flash_cnt <= '0;
      flash_phase <= 1'b1;
    end else if (state != LS_PEND) begin
      flash_cnt <= '0;
      flash_phase <= 1'b1;
    end else if (flash_wrap) begin
      flash_cnt <= '0;
      flash_phase <= !flash_phase; // see [RL12]
    end else if (tick) begin
      flash_cnt <= flash_cnt + 16'h1;
    end
  end

  wire logic next_led = (next_state == LS_ON) ||
                        ((next_state == LS_PEND) && (state != LS_PEND || flash_phase != flash_wrap));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      power_led <= 1'b0;
    end else begin
      power_led <= next_led; // see [RL12] [RL18]
    end
  end

  // Settings
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      delay_ms <= DELAY_RST_MS;
      ffwd_en <= 1'b0;
      mod_en <= 1'b0;
      sweep_en <= 1'b0;
    end else begin
      if (wr_delay) begin
        delay_ms <= cmd_arg[15:0]; // see [RL3]
      end
      if (wr_ffwd) begin
        ffwd_en <= arg_bit; // see [RL8]
      end
      if (wr_mod) begin
        mod_en <= arg_bit; // see [RL8]
      end
      if (wr_sweep) begin
        sweep_en <= arg_bit; // see [RL8] [RL13]
      end
    end
  end

  // Feedforward; each accepted feedforward enable re-captures the reference
  wire logic signed [VAL_W:0] ff_diff = {piezo_actual[VAL_W-1], piezo_actual} -
                                        {piezo_ref[VAL_W-1], piezo_ref};
  wire logic signed [FF_W-1:0] ff_prod = ffwd_coeff * ff_diff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      piezo_ref <= '0;
      ffwd_current <= '0;
    end else begin
      if (wr_ffwd && arg_bit) begin
        piezo_ref <= piezo_setpoint; // see [RL9]
      end
      ffwd_current <= ffwd_en ? ff_prod : '0; // see [RL10]
    end
  end

  // Replies
  always_comb begin
    qry_val = '0;
    unique case (cmd_code)
      CMD_DELAY_QRY: qry_val = {16'h0, delay_ms}; // see [RL6]
      CMD_FFWD_QRY: qry_val = {31'h0, ffwd_en}; // see [RL11]
      CMD_MOD_QRY: qry_val = {31'h0, mod_en}; // see [RL11]
      CMD_OUT_QRY: qry_val = {31'h0, !st_off}; // see [RL11]
      CMD_SWEEP_QRY: qry_val = {31'h0, sweep_en}; // see [RL11]
      CMD_CUR_QRY: qry_val = {16'h0, mag(diode_current)}; // see [RL14]
      CMD_TEMP_QRY: qry_val = {16'h0, mag(diode_temp)}; // see [RL15]
      CMD_PIEZO_QRY: qry_val = {16'h0, mag(piezo_actual)}; // see [RL17]
      default: qry_val = '0;
    endcase
  end

  wire lohc_rsp_t next_rsp = no_arg ? RSP_NO_PARAM : // see [RL1]
                             accept ? RSP_OK : // see [RL3] [RL8]
                             is_set_cmd ? RSP_RANGE : // see [RL2] [RL7]
                             is_qry_cmd ? RSP_VALUE : RSP_UNKNOWN;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rsp_valid <= 1'b0;
      rsp_code <= RSP_OK;
      rsp_value <= '0;
    end else begin
      rsp_valid <= cmd_valid;
      if (cmd_valid) begin
        rsp_code <= next_rsp;
        rsp_value <= is_qry_cmd ? qry_val : '0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_no_arg;
    no_arg |=> rsp_valid && rsp_code == RSP_NO_PARAM && $stable(delay_ms) &&
      $stable({ffwd_en, mod_en, sweep_en});
  endproperty
  a_no_arg: assert property (p_no_arg) else $error("missing argument not refused"); // see [RL1]

  property p_delay_range;
    cmd_valid && cmd_code == CMD_DELAY_SET && cmd_has_arg && !delay_arg_ok
      |=> rsp_code == RSP_RANGE && $stable(delay_ms);
  endproperty
  a_delay_range: assert property (p_delay_range) else $error("bad delay taken"); // see [RL2]

  property p_delay_write;
    wr_delay |=> delay_ms == $past(cmd_arg[15:0]) && rsp_code == RSP_OK;
  endproperty
  a_delay_write: assert property (p_delay_write) else $error("delay not stored"); // see [RL3]

  property p_on_cause;
    $rose(laser_on) |-> $past(state == LS_PEND && tick && remain == 16'h1);
  endproperty
  a_on_cause: assert property (p_on_cause) else $error("output on before delay"); // see [RL4]

  property p_button_start;
    btn_rise && st_off && !over_temp && !cmd_valid
      |=> state == LS_PEND && remain == $past(delay_ms) && !laser_on;
  endproperty
  a_button_start: assert property (p_button_start) else $error("button start wrong"); // see [RL5]

  property p_delay_query;
    cmd_valid && cmd_code == CMD_DELAY_QRY
      |=> rsp_code == RSP_VALUE && rsp_value == {16'h0, $past(delay_ms)};
  endproperty
  a_delay_query: assert property (p_delay_query) else $error("delay query wrong"); // see [RL6]

  property p_en_range;
    cmd_valid && is_en_cmd && cmd_has_arg && cmd_arg > 32'h1
      |=> rsp_code == RSP_RANGE && $stable({ffwd_en, mod_en, sweep_en});
  endproperty
  a_en_range: assert property (p_en_range) else $error("bad enable taken"); // see [RL7]

  property p_en_write;
    wr_mod |=> mod_en == $past(arg_bit) && rsp_code == RSP_OK;
  endproperty
  a_en_write: assert property (p_en_write) else $error("enable not applied"); // see [RL8]

  property p_ff_latch;
    wr_ffwd && arg_bit |=> piezo_ref == $past(piezo_setpoint) ##1 ffwd_en;
  endproperty
  a_ff_latch: assert property (p_ff_latch) else $error("reference not latched"); // see [RL9]

  property p_ff_value;
    ffwd_en |=> ffwd_current == $past(ffwd_coeff) * ($past(piezo_actual) - $past(piezo_ref));
  endproperty
  a_ff_value: assert property (p_ff_value) else $error("feedforward current wrong"); // see [RL10]

  property p_sweep_query;
    cmd_valid && cmd_code == CMD_SWEEP_QRY |=> rsp_value == {31'h0, $past(sweep_en)};
  endproperty
  a_sweep_query: assert property (p_sweep_query) else $error("sweep query wrong"); // see [RL11]

  property p_flash;
    state == LS_PEND && flash_wrap && next_state == LS_PEND
      |=> power_led != $past(power_led);
  endproperty
  a_flash: assert property (p_flash) else $error("indicator not flashing"); // see [RL12]

  property p_sweep_write;
    wr_sweep |=> sweep_en == $past(arg_bit);
  endproperty
  a_sweep_write: assert property (p_sweep_write) else $error("sweep not applied"); // see [RL13]

  property p_cur_query;
    cmd_valid && cmd_code == CMD_CUR_QRY |=> rsp_value == {16'h0, mag($past(diode_current))};
  endproperty
  a_cur_query: assert property (p_cur_query) else $error("current query wrong"); // see [RL14]

  property p_over_temp;
    over_temp |=> !laser_on && state == LS_OFF;
  endproperty
  a_over_temp: assert property (p_over_temp) else $error("no thermal shutdown"); // see [RL16]

  property p_cancel;
    state == LS_PEND && wr_out && !arg_bit |=> state == LS_OFF && !power_led [*2];
  endproperty
  a_cancel: assert property (p_cancel) else $error("pending turn-on not cancelled"); // see [RL18]

  c_reach_on: cover property (state == LS_PEND ##1 state == LS_ON);
  c_cancel: cover property (state == LS_PEND && wr_out && !arg_bit);
  c_thermal: cover property (laser_on && over_temp);
  c_button: cover property (btn_rise && st_off);
endmodule
